/* design/acdc_top.sv */
// AHB-Lite register file and interrupt logic for four DMA contexts.
// Assumes a word-only AHB-Lite master and a memory agent that grants
// descriptor fetches and reports transfer completion per context.
`timescale 1ns/100ps
module acdc_top (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Software reset
	input wire logic soft_reset,
	// Descriptor fetch requests
	output logic [acdc_pkg::ACDC_NCTX-1:0] fetch_req,
	output logic [acdc_pkg::ACDC_NCTX-1:0]
		[acdc_pkg::ACDC_PTR_ADDR_W-1:0] descriptor_block_pointer,
	output logic [acdc_pkg::ACDC_NCTX-1:0]
		[acdc_pkg::ACDC_PTR_CNT_W-1:0] fetch_count,
	input wire logic [acdc_pkg::ACDC_NCTX-1:0] fetch_gnt,
	// Transfer results
	input wire logic [acdc_pkg::ACDC_NCTX-1:0] xfer_done,
	input wire logic [acdc_pkg::ACDC_NCTX-1:0] xfer_fatal,
	input wire logic [acdc_pkg::ACDC_EVT_W-1:0] xfer_event,
	input wire logic [acdc_pkg::ACDC_SPD_W-1:0] xfer_speed,
	// Interrupt
	output logic irq
);
	import acdc_pkg::*;

	typedef struct packed {
		logic hreadyout;
		logic [31:0] hrdata;
		logic hresp;
		logic wr_pend;
		logic rd_pend;
		logic [ACDC_DEC_W-1:0] addr;
		logic [ACDC_NCTX-1:0] run;
		logic [ACDC_NCTX-1:0] start;
		logic [ACDC_NCTX-1:0] wake;
		logic [ACDC_NCTX-1:0] dead;
		logic [ACDC_NCTX-1:0][ACDC_SPD_W-1:0] speed;
		logic [ACDC_NCTX-1:0][ACDC_EVT_W-1:0] evt;
		logic [ACDC_NCTX-1:0][31:0] ptr;
		logic [ACDC_IRQ_W-1:0] irq_stat;
		logic [ACDC_IRQ_W-1:0] irq_mask;
		logic irq;
	} acdc_top_state_type;

	acdc_top_state_type s_r;
	acdc_top_state_type s_nxt;
	logic [31:0] rd_word;
	logic [ACDC_NCTX-1:0] ctx_req;
	logic [ACDC_NCTX-1:0] ctx_active;
	logic [ACDC_NCTX-1:0] ctx_wclr;
	logic addr_take;

	assign addr_take = hsel && hready && (htrans == ACDC_HTRANS_NONSEQ);

	// Read data is built from registered state, one cycle after the
	// address phase, so a read right after a write sees the new value.
	always_comb begin
		rd_word = 32'h0;
		for (int i = 0; i < ACDC_NCTX; i++) begin
			if (s_r.addr == ACDC_SET_OFS[i] ||
				s_r.addr == ACDC_CLR_OFS[i]) begin
				// Unassigned bits stay zero.
				rd_word[ACDC_RUN_BIT] = s_r.run[i];
				rd_word[ACDC_WAKE_BIT] = s_r.wake[i];
				rd_word[ACDC_DEAD_BIT] = s_r.dead[i];
				rd_word[ACDC_ACTIVE_BIT] = ctx_active[i];
				rd_word[ACDC_SPD_LSB +: ACDC_SPD_W] = s_r.speed[i];
				rd_word[ACDC_EVT_LSB +: ACDC_EVT_W] = s_r.evt[i];
			end
			if (s_r.addr == ACDC_PTR_OFS[i]) begin
				rd_word = s_r.ptr[i];
			end
		end
		if (s_r.addr == ACDC_IRQ_STAT_OFS) begin
			rd_word[ACDC_IRQ_W-1:0] = s_r.irq_stat;
		end
		if (s_r.addr == ACDC_IRQ_MASK_OFS) begin
			rd_word[ACDC_IRQ_W-1:0] = s_r.irq_mask;
		end
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.start = '0;
		s_nxt.hresp = ACDC_HRESP_OKAY;
		// Device clear of resume comes first so a software set wins.
		for (int i = 0; i < ACDC_NCTX; i++) begin
			if (ctx_wclr[i]) begin
				s_nxt.wake[i] = 1'b0;
			end
		end
		// Write data phase.
		if (s_r.wr_pend) begin
			s_nxt.wr_pend = 1'b0;
			for (int i = 0; i < ACDC_NCTX; i++) begin
				if (s_r.addr == ACDC_SET_OFS[i]) begin
					if (hwdata[ACDC_RUN_BIT]) begin
						s_nxt.start[i] = !s_r.run[i];
						s_nxt.run[i] = 1'b1;
					end
					if (hwdata[ACDC_WAKE_BIT]) begin
						s_nxt.wake[i] = 1'b1;
					end
				end
				if (s_r.addr == ACDC_CLR_OFS[i]) begin
					if (hwdata[ACDC_RUN_BIT]) begin
						s_nxt.run[i] = 1'b0;
						s_nxt.dead[i] = 1'b0;
					end
					if (hwdata[ACDC_WAKE_BIT]) begin
						s_nxt.wake[i] = 1'b0;
					end
				end
				if (s_r.addr == ACDC_PTR_OFS[i]) begin
					s_nxt.ptr[i] = hwdata;
				end
			end
			if (s_r.addr == ACDC_IRQ_MASK_OFS) begin
				s_nxt.irq_mask = hwdata[ACDC_IRQ_W-1:0];
			end
		end
		// Read data phase: one wait state, then the data.
		if (s_r.rd_pend) begin
			s_nxt.rd_pend = 1'b0;
			s_nxt.hreadyout = 1'b1;
			s_nxt.hrdata = rd_word;
			if (s_r.addr == ACDC_IRQ_STAT_OFS) begin
				s_nxt.irq_stat = '0;
			end
		end
		// Address phase; non-word writes are dropped.
		if (addr_take) begin
			s_nxt.addr = haddr[ACDC_DEC_W-1:0];
			if (hwrite) begin
				s_nxt.wr_pend = (hsize == ACDC_HSIZE_WORD);
			end else begin
				s_nxt.rd_pend = 1'b1;
				s_nxt.hreadyout = 1'b0;
			end
		end
		// Transfer results are applied last so they win over clears.
		for (int i = 0; i < ACDC_NCTX; i++) begin
			if (ctx_active[i] && (xfer_done[i] || xfer_fatal[i])) begin
				s_nxt.evt[i] = xfer_event;
				// Transmit contexts store the code too; it carries no meaning.
				s_nxt.speed[i] = xfer_speed;
			end
			if (ctx_active[i] && xfer_done[i]) begin
				s_nxt.irq_stat[i] = 1'b1;
			end
			if (ctx_active[i] && xfer_fatal[i]) begin
				s_nxt.dead[i] = 1'b1;
				s_nxt.irq_stat[ACDC_NCTX + i] = 1'b1;
			end
		end
		if (soft_reset) begin
			s_nxt.run = '0;
			s_nxt.start = '0;
		end
		s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r.hreadyout <= 1'b1;
			s_r.hrdata <= 32'h0;
			s_r.hresp <= ACDC_HRESP_OKAY;
			s_r.wr_pend <= 1'b0;
			s_r.rd_pend <= 1'b0;
			s_r.addr <= '0;
			s_r.run <= '0;
			s_r.start <= '0;
			s_r.wake <= '0;
			s_r.dead <= '0;
			s_r.speed <= {ACDC_NCTX{ACDC_SPD_RST}};
			s_r.evt <= {ACDC_NCTX{ACDC_EVT_RST}};
			s_r.ptr <= {ACDC_NCTX{ACDC_PTR_RST}};
			s_r.irq_stat <= ACDC_IRQ_RST;
			s_r.irq_mask <= ACDC_IRQ_RST;
			s_r.irq <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	for (genvar g = 0; g < ACDC_NCTX; g++) begin : gen_ctx
		acdc_ctx_if cif ();
		assign cif.run = s_r.run[g];
		assign cif.start = s_r.start[g];
		assign cif.wake = s_r.wake[g];
		assign cif.dead = s_r.dead[g];
		// A zero count marks the address invalid.
		assign cif.cnt_nz = |s_r.ptr[g][ACDC_PTR_CNT_W-1:0];
		assign cif.gnt = fetch_gnt[g];
		assign cif.done = xfer_done[g];
		assign cif.fatal = xfer_fatal[g];
		assign ctx_req[g] = cif.fetch_req;
		assign ctx_active[g] = cif.active;
		assign ctx_wclr[g] = cif.wake_clr;
		acdc_context u_ctx (
			.hclk(hclk),
			.hresetn(hresetn),
			.cif(cif.ctx)
		);
		assign descriptor_block_pointer[g] =
			s_r.ptr[g][ACDC_PTR_ADDR_LSB +: ACDC_PTR_ADDR_W];
		assign fetch_count[g] = s_r.ptr[g][ACDC_PTR_CNT_W-1:0];
	end

	assign hreadyout = s_r.hreadyout;
	assign hrdata = s_r.hrdata;
	assign hresp = s_r.hresp;
	assign fetch_req = ctx_req;
	assign irq = s_r.irq;
endmodule : acdc_top

/* design/acdc_pkg.sv */
// Constants, register map and types for the asynchronous DMA context control.
// Assumes an AHB-Lite master with word accesses and one clock, hclk.
// Operation
// - Descriptors are processed only while software keeps the run bit set.
// - Only hardware reset or software reset clears run without software.
// - Software sets the resume bit to continue or restart processing.
// - The resume bit is cleared on every descriptor fetch.
// - An unrecoverable error sets the fatal error flag of that context.
// - Software clearing run also clears the fatal error flag.
// - The activity flag is one while descriptors are being processed.
// - Speed codes: 000 is 100, 001 is 200, 010 is 400 Mbit/s.
// - The speed field is meaningful only for receive contexts.
// - Event code holds the link acknowledge or an internal error code.
// - Reserved control bits 31:16, 14:13 and 9:8 read as zero.
// - Enabling run fetches the first block from the command pointer.
// - Pointer bits 31:4 give the upper bits of a 16-byte aligned block.
// - Pointer bits 3:0 give the count of contiguous descriptors.
// - A descriptor count of zero means the address must not be used.
package acdc_pkg;
	localparam int ACDC_NCTX = 4;
	localparam int ACDC_DEC_W = 12;
	localparam logic [ACDC_DEC_W-1:0] ACDC_SET_OFS [ACDC_NCTX] =
		'{12'h180, 12'h1a0, 12'h1c0, 12'h1e0};
	localparam logic [ACDC_DEC_W-1:0] ACDC_CLR_OFS [ACDC_NCTX] =
		'{12'h184, 12'h1a4, 12'h1c4, 12'h1e4};
	localparam logic [ACDC_DEC_W-1:0] ACDC_PTR_OFS [ACDC_NCTX] =
		'{12'h19c, 12'h1ac, 12'h1cc, 12'h1ec};
	localparam logic [ACDC_DEC_W-1:0] ACDC_IRQ_STAT_OFS = 12'h1f0;
	localparam logic [ACDC_DEC_W-1:0] ACDC_IRQ_MASK_OFS = 12'h1f4;
	// Control register fields.
	localparam int ACDC_RUN_BIT = 15;
	localparam int ACDC_WAKE_BIT = 12;
	localparam int ACDC_DEAD_BIT = 11;
	localparam int ACDC_ACTIVE_BIT = 10;
	localparam int ACDC_SPD_LSB = 5;
	localparam int ACDC_SPD_W = 3;
	localparam int ACDC_EVT_LSB = 0;
	localparam int ACDC_EVT_W = 5;
	// Command pointer fields.
	localparam int ACDC_PTR_ADDR_LSB = 4;
	localparam int ACDC_PTR_ADDR_W = 28;
	localparam int ACDC_PTR_CNT_W = 4;
	// Interrupt status: bit n is completion of context n, bit n+4 fatal.
	localparam int ACDC_IRQ_W = 2 * ACDC_NCTX;
	// Speed codes.
	localparam logic [ACDC_SPD_W-1:0] ACDC_SPD_S100 = 3'h0;
	localparam logic [ACDC_SPD_W-1:0] ACDC_SPD_S200 = 3'h1;
	localparam logic [ACDC_SPD_W-1:0] ACDC_SPD_S400 = 3'h2;
	// Reset values.
	localparam logic [31:0] ACDC_PTR_RST = 32'h0;
	localparam logic [ACDC_EVT_W-1:0] ACDC_EVT_RST = 5'h0;
	localparam logic [ACDC_SPD_W-1:0] ACDC_SPD_RST = ACDC_SPD_S100;
	localparam logic [ACDC_IRQ_W-1:0] ACDC_IRQ_RST = 8'h0;
	// AHB-Lite encodings.
	localparam logic [1:0] ACDC_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] ACDC_HSIZE_WORD = 3'h2;
	localparam logic ACDC_HRESP_OKAY = 1'h0;
	typedef enum logic [2:0] {
		ACDC_ST_IDLE = 3'h1,
		ACDC_ST_FETCH = 3'h2,
		ACDC_ST_XFER = 3'h4
	} acdc_state_type;
endpackage : acdc_pkg

/* design/acdc_ctx_if.sv */
// Signals between the register file and one context sequencer.
// Assumes both ends run on hclk.
`timescale 1ns/100ps
interface acdc_ctx_if;
	logic run;
	logic start;
	logic wake;
	logic dead;
	logic cnt_nz;
	logic gnt;
	logic done;
	logic fatal;
	logic fetch_req;
	logic active;
	logic wake_clr;
	modport regs (
		output run, start, wake, dead, cnt_nz, gnt, done, fatal,
		input fetch_req, active, wake_clr
	);
	modport ctx (
		input run, start, wake, dead, cnt_nz, gnt, done, fatal,
		output fetch_req, active, wake_clr
	);
endinterface : acdc_ctx_if

/* design/acdc_context.sv */
// Sequencer of one asynchronous DMA context: fetch request and activity.
// Assumes the register file owns run, resume and fatal flags.
`timescale 1ns/100ps
module acdc_context (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Register file side
	acdc_ctx_if.ctx cif
);
	import acdc_pkg::*;

	typedef struct packed {
		acdc_state_type state;
		logic start_pend;
		logic fetch_req;
		logic active;
		logic wake_clr;
	} acdc_ctx_state_type;

	acdc_ctx_state_type s_r;
	acdc_ctx_state_type s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.wake_clr = 1'b0;
		if (cif.start) begin
			s_nxt.start_pend = 1'b1;
		end
		case (s_r.state)
			ACDC_ST_IDLE: begin
				// A dead context stays idle until software clears run.
				if (cif.run && !cif.dead && cif.cnt_nz &&
					(s_nxt.start_pend || cif.wake)) begin
					s_nxt.state = ACDC_ST_FETCH;
					s_nxt.fetch_req = 1'b1;
					s_nxt.active = 1'b1;
					s_nxt.start_pend = 1'b0;
				end
			end
			ACDC_ST_FETCH: begin
				if (!cif.run) begin
					s_nxt.state = ACDC_ST_IDLE;
					s_nxt.fetch_req = 1'b0;
					s_nxt.active = 1'b0;
				end else if (cif.gnt) begin
					s_nxt.state = ACDC_ST_XFER;
					s_nxt.fetch_req = 1'b0;
					s_nxt.wake_clr = 1'b1;
				end
			end
			ACDC_ST_XFER: begin
				if (!cif.run || cif.done || cif.fatal) begin
					s_nxt.state = ACDC_ST_IDLE;
					s_nxt.active = 1'b0;
				end
			end
			default: begin
				s_nxt.state = ACDC_ST_IDLE;
				s_nxt.fetch_req = 1'b0;
				s_nxt.active = 1'b0;
			end
		endcase
		if (!cif.run) begin
			s_nxt.start_pend = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '{state: ACDC_ST_IDLE, default: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign cif.fetch_req = s_r.fetch_req;
	assign cif.active = s_r.active;
	assign cif.wake_clr = s_r.wake_clr;
endmodule : acdc_context

/* sim/acdc_properties.sv */
// Concurrent checks on the ports of the DMA context control block.
// Assumes one clock, hclk, and the asynchronous active-low reset hresetn.
`timescale 1ns/100ps
module acdc_properties (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	// Fetch link
	input wire logic soft_reset,
	input wire logic [3:0] fetch_req,
	input wire logic [3:0][27:0] descriptor_block_pointer,
	input wire logic [3:0][3:0] fetch_count,
	input wire logic [3:0] fetch_gnt
);
	logic go;
	assign go = hsel && hready && htrans == 2'h2;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	a_resp_okay: assert property (hresp == 1'h0)
		else $error("hresp is not OKAY");
	a_read_wait: assert property (
		go && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_nowait: assert property (go && hwrite |=> hreadyout)
		else $error("write inserted a wait state");
	a_ptr_by_write: assert property (
		!$stable(descriptor_block_pointer) |-> $past(go && hwrite, 2))
		else $error("pointer changed without a write");
	a_rdata_by_read: assert property (
		!$stable(hrdata) |-> $past(go && !hwrite, 2))
		else $error("hrdata changed without a read");
	a_soft_stop: assert property (
		soft_reset [*3] |-> fetch_req == 4'h0)
		else $error("fetch survived software reset");
	for (genvar i = 0; i < 4; i++) begin : g_ctx
		a_gnt_drops: assert property (
			fetch_req[i] && fetch_gnt[i] |=> !fetch_req[i])
			else $error("fetch request held after grant");
		a_count_valid: assert property (
			$rose(fetch_req[i]) |-> fetch_count[i] != 4'h0)
			else $error("fetch with zero descriptor count");
	end
endmodule : acdc_properties

bind acdc_top acdc_properties acdc_properties_inst (.hclk, .hresetn, .hsel,
	.htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp, .soft_reset,
	.fetch_req, .descriptor_block_pointer, .fetch_count, .fetch_gnt);

/* sim/acdc_mem_model.sv */
// Memory agent: grants descriptor fetches and reports transfer results.
// Assumes the bench sets event, speed, failure and latency per transfer.
`timescale 1ns/100ps
module acdc_mem_model (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Fetch link
	input wire logic [3:0] fetch_req,
	output logic [3:0] fetch_gnt,
	output logic [3:0] xfer_done,
	output logic [3:0] xfer_fatal,
	output logic [4:0] xfer_event,
	output logic [2:0] xfer_speed,
	// Bench commands
	input wire logic [4:0] ev,
	input wire logic [2:0] spd,
	input wire logic [3:0] fail,
	input wire logic [3:0] lat
);
	int i;
	initial begin
		fetch_gnt = 4'h0;
		xfer_done = 4'h0;
		xfer_fatal = 4'h0;
		xfer_event = 5'h0;
		xfer_speed = 3'h0;
		forever begin
			@(posedge hclk);
			fetch_gnt <= 4'h0;
			xfer_done <= 4'h0;
			xfer_fatal <= 4'h0;
			// Result lines carry nothing valid outside a result pulse.
			xfer_event <= ~xfer_event;
			xfer_speed <= ~xfer_speed;
			if (hresetn && fetch_req != 4'h0) begin
				i = 0;
				while (!fetch_req[i])
					i++;
				repeat (lat) @(posedge hclk);
				if (fetch_req[i]) begin
					fetch_gnt[i] <= 1'h1;
					@(posedge hclk);
					fetch_gnt <= 4'h0;
					repeat (lat) @(posedge hclk);
					xfer_done[i] <= !fail[i];
					xfer_fatal[i] <= fail[i];
					xfer_event <= ev;
					xfer_speed <= spd;
				end
			end
		end
	end
endmodule : acdc_mem_model

/* sim/acdc_top_tb.sv */
// Register-level bench of the DMA context control block.
// Assumes the memory agent model and the bound property checker.
`timescale 1ns/100ps
module acdc_top_tb;
	import acdc_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, soft_reset, irq;
	wire logic hready;
	logic [31:0] haddr, hwdata, hrdata, d, p;
	logic [1:0] htrans;
	logic [2:0] hsize, xfer_speed, spd;
	logic [3:0] fetch_req, fetch_gnt, xfer_done, xfer_fatal, fail, lat;
	logic [3:0][27:0] dbp;
	logic [3:0][3:0] fetch_count;
	logic [4:0] xfer_event, ev;
	logic [2:0] sp [4] = '{ACDC_SPD_S100, ACDC_SPD_S200, ACDC_SPD_S400,
		ACDC_SPD_S200};
	int miscompares = 0;
	int n_tests = 0;
	localparam logic [31:0] run_m = 32'h1 << ACDC_RUN_BIT;
	localparam logic [31:0] wake_m = 32'h1 << ACDC_WAKE_BIT;
	localparam logic [31:0] dead_m = 32'h1 << ACDC_DEAD_BIT;
	localparam logic [31:0] act_m = 32'h1 << ACDC_ACTIVE_BIT;
	assign hready = hreadyout;
	acdc_top acdc_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .soft_reset,
		.fetch_req, .descriptor_block_pointer(dbp), .fetch_count, .fetch_gnt,
		.xfer_done, .xfer_fatal, .xfer_event, .xfer_speed, .irq);
	acdc_mem_model acdc_mem_model_inst (.hclk, .hresetn, .fetch_req,
		.fetch_gnt, .xfer_done, .xfer_fatal, .xfer_event, .xfer_speed, .ev,
		.spd, .fail, .lat);
	initial begin
		hclk = 1'h0;
		forever #20 hclk = ~hclk;
	end
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (20000) @(posedge hclk);
		miscompares++;
		wrap_up();
	end
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Entered just after a rising edge; returns at the edge that ends
	// the data phase.
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] wd);
		hsel <= 1'h1;
		haddr <= {20'h0, a};
		hwrite <= w;
		htrans <= ACDC_HTRANS_NONSEQ;
		do @(posedge hclk); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'h1);
		d = hrdata;
	endtask : xfer
	task automatic rdc(input logic [11:0] a, input logic [31:0] e, m);
		xfer(1'h0, a, 32'h0);
		chk($sformatf("read %h", a), e, d & m);
	endtask : rdc
	task automatic wirq;
		for (int k = 0; k < 60 && irq !== 1'h1; k++)
			@(posedge hclk);
	endtask : wirq
	initial begin
		{hresetn, hsel, hwrite, soft_reset, haddr, hwdata, htrans} = '0;
		{ev, spd, fail} = '0;
		hsize = ACDC_HSIZE_WORD;
		lat = 4'h4;
		repeat (6) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		for (int n = 0; n < 4; n++) begin
			rdc(ACDC_SET_OFS[n], 32'h0, 32'hffffef00);
			rdc(ACDC_PTR_OFS[n], ACDC_PTR_RST, '1);
		end
		xfer(1'h1, ACDC_PTR_OFS[0], 32'h00001230);
		xfer(1'h1, ACDC_SET_OFS[0], run_m | wake_m);
		repeat (8) @(posedge hclk);
		chk("fetch_req", 32'h0, {28'h0, fetch_req});
		rdc(ACDC_CLR_OFS[0], run_m | wake_m, 32'hffffff00);
		xfer(1'h1, ACDC_CLR_OFS[0], run_m | wake_m);
		rdc(ACDC_SET_OFS[0], 32'h0, 32'hffffff00);
		xfer(1'h1, ACDC_IRQ_MASK_OFS, 32'hff);
		rdc(ACDC_IRQ_MASK_OFS, 32'hff, '1);
		for (int n = 0; n < 4; n++) begin
			p = {24'h0abcde, 4'(n), 4'(n + 1)};
			ev <= 5'h11 + 5'(n);
			spd <= sp[n];
			xfer(1'h1, ACDC_PTR_OFS[n], p);
			xfer(1'h1, ACDC_SET_OFS[n], run_m | wake_m);
			for (int k = 0; k < 20 && fetch_req[n] !== 1'h1; k++)
				@(posedge hclk);
			chk("fetch_req", 32'h1, {31'h0, fetch_req[n]});
			chk("pointer", {4'h0, p[31:4]}, {4'h0, dbp[n]});
			chk("count", {28'h0, p[3:0]}, {28'h0, fetch_count[n]});
			rdc(ACDC_SET_OFS[n], run_m | wake_m | act_m, '1);
			wirq();
			chk("irq", 32'h1, {31'h0, irq});
			rdc(ACDC_CLR_OFS[n], run_m | {24'h0, spd, ev}, '1);
			rdc(ACDC_IRQ_STAT_OFS, 32'h1 << n, '1);
			rdc(ACDC_IRQ_STAT_OFS, 32'h0, '1);
			chk("irq", 32'h0, {31'h0, irq});
			xfer(1'h1, ACDC_CLR_OFS[n], run_m);
		end
		fail <= 4'h2;
		ev <= 5'h1b;
		xfer(1'h1, ACDC_SET_OFS[1], run_m | wake_m);
		wirq();
		rdc(ACDC_SET_OFS[1], run_m | dead_m | 32'h1b, 32'hffffef1f);
		rdc(ACDC_IRQ_STAT_OFS, 32'h20, '1);
		xfer(1'h1, ACDC_SET_OFS[1], wake_m);
		repeat (10) @(posedge hclk);
		chk("fetch_req", 32'h0, {28'h0, fetch_req});
		xfer(1'h1, ACDC_CLR_OFS[1], run_m);
		rdc(ACDC_SET_OFS[1], 32'h0, 32'hffffef00);
		fail <= 4'h0;
		xfer(1'h1, ACDC_IRQ_MASK_OFS, 32'h0);
		xfer(1'h1, ACDC_SET_OFS[2], run_m | wake_m);
		repeat (30) @(posedge hclk);
		chk("irq", 32'h0, {31'h0, irq});
		rdc(ACDC_IRQ_STAT_OFS, 32'h4, '1);
		xfer(1'h1, ACDC_CLR_OFS[2], run_m);
		lat <= 4'hf;
		xfer(1'h1, ACDC_SET_OFS[3], run_m | wake_m);
		for (int k = 0; k < 20 && fetch_req[3] !== 1'h1; k++)
			@(posedge hclk);
		xfer(1'h1, ACDC_CLR_OFS[3], run_m);
		repeat (3) @(posedge hclk);
		chk("fetch_req", 32'h0, {28'h0, fetch_req});
		rdc(ACDC_SET_OFS[3], 32'h0, 32'hffffef00);
		repeat (40) @(posedge hclk);
		lat <= 4'h4;
		xfer(1'h1, ACDC_SET_OFS[0], run_m);
		soft_reset <= 1'h1;
		repeat (4) @(posedge hclk);
		soft_reset <= 1'h0;
		@(posedge hclk);
		rdc(ACDC_SET_OFS[0], 32'h0, run_m);
		hsize <= 3'h1;
		xfer(1'h1, ACDC_PTR_OFS[2], 32'h0);
		hsize <= ACDC_HSIZE_WORD;
		rdc(ACDC_PTR_OFS[2], 32'h0abcde23, '1);
		rdc(12'h100, 32'h0, '1);
		wrap_up();
	end
endmodule : acdc_top_tb
